// ===== core/tcdl_cfg.svh
// Constants for the twelve-channel serial code loader
`ifndef TCDL_CFG_SVH
`define TCDL_CFG_SVH

// ----------------------------------------------------------------------
// Word layout
// ----------------------------------------------------------------------
`define TCDL_WORD_BITS 12
`define TCDL_ADDR_W 4
`define TCDL_ADDR_MSB 11
`define TCDL_ADDR_LSB 8
`define TCDL_CODE_W 8
`define TCDL_CODE_MSB 7
`define TCDL_CODE_LSB 0

// ----------------------------------------------------------------------
// Channels and reset values
// ----------------------------------------------------------------------
`define TCDL_CHANNELS 12
`define TCDL_MIDSCALE 8'h80

// ----------------------------------------------------------------------
// Input sampling
// ----------------------------------------------------------------------
`define TCDL_PIN_COUNT 4
`define TCDL_PIN_SCK 3
`define TCDL_PIN_SEL 2
`define TCDL_PIN_SDI 1
`define TCDL_PIN_PWR 0

`endif

// ===== core/tcdl_pkg.sv
// Types shared by the serial code loader modules
`include "tcdl_cfg.svh"

package tcdl_pkg;
   typedef logic [`TCDL_CODE_W-1:0] tcdl_code_t;
   typedef logic [`TCDL_ADDR_W-1:0] tcdl_addr_t;
   typedef logic [`TCDL_WORD_BITS-1:0] tcdl_word_t;
   typedef enum logic [0:0] {
      TCDL_ST_IDLE,
      TCDL_ST_SHIFT
   } tcdl_state_t;
endpackage

// ===== core/tcdl_chan_if.sv
// Write path between the serial front end and the channel register bank
`timescale 1ns/100ps
`include "tcdl_cfg.svh"

interface tcdl_chan_if
   import tcdl_pkg::*;
   #(parameter int N_CH = `TCDL_CHANNELS);
   logic preset_n;
   logic wr_en;
   tcdl_addr_t wr_addr;
   tcdl_code_t wr_code;
   tcdl_code_t codes [N_CH];

   // Front end drives the write strobe, bank returns stored codes
   modport writer (
      output preset_n,
      output wr_en,
      output wr_addr,
      output wr_code,
      input codes
   );
   modport bank (
      input preset_n,
      input wr_en,
      input wr_addr,
      input wr_code,
      output codes
   );
endinterface

// ===== core/tcdl_chan_bank.sv
// Twelve channel code registers with asynchronous midscale preset
`timescale 1ns/100ps
`include "tcdl_cfg.svh"

module tcdl_chan_bank
   import tcdl_pkg::*;
   #(parameter int N_CH = `TCDL_CHANNELS) (
   // System
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   // Write path and stored codes
   tcdl_chan_if.bank bus
);

   // ----------------------------------------------------------------------
   // Channel registers
   // ----------------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < N_CH; i++) begin : g_ch
         // Preset pin acts with no clock, so it sits on the async input
         always_ff @(posedge clk or posedge sys_rst
                     or negedge bus.preset_n) begin
            if (sys_rst) begin
               bus.codes[i] <= `TCDL_MIDSCALE;
            end else if (!bus.preset_n) begin
               bus.codes[i] <= `TCDL_MIDSCALE;
            end else if (ce && bus.wr_en
                         && bus.wr_addr == `TCDL_ADDR_W'(i)) begin
               // Address value plus one is the channel number
               bus.codes[i] <= bus.wr_code;
            end
         end

         // Only the addressed channel may move
         a_only_target: assert property (
            @(posedge clk) disable iff (sys_rst || !bus.preset_n)
            !(ce && bus.wr_en && bus.wr_addr == `TCDL_ADDR_W'(i))
            |=> $stable(bus.codes[i]))
            else $error("untargeted channel changed");

         // Strobe lands in the channel named by address plus one
         a_addr_map: assert property (
            @(posedge clk) disable iff (sys_rst || !bus.preset_n)
            ce && bus.wr_en && bus.wr_addr == `TCDL_ADDR_W'(i)
            |=> bus.codes[i] == $past(bus.wr_code))
            else $error("channel did not take its code");

         // Preset holds midscale while low
         a_preset_mid: assert property (
            @(posedge clk) disable iff (sys_rst)
            !bus.preset_n |-> bus.codes[i] == `TCDL_MIDSCALE)
            else $error("preset did not give midscale");
      end
   endgenerate

endmodule

// ===== core/tcdl_loader.sv
// Serial front end and top of the twelve-channel code loader
//
// Notes on behaviour
// - A word is 12 bits: 4 address bits then 8 code bits, MSB first.
// - Each rising serial clock edge while select is low shifts one data bit in.
// - Select is active low; its rising edge decodes and loads a channel.
// - Channel number is address plus one, address 0 to 11 in order.
// - Word bits 7 to 0 are the code; bits 11 to 8 only address.
// - Each word changes only the one addressed channel.
// - Power-down input stops the converters but keeps every stored code.
// - Leaving power-down restores outputs from held codes, no reload.
// - Low preset sets all channel registers to midscale code 128.
// - Each channel's stored code is presented to its converter.
// - Preset acts without any clock and loads hex 80 everywhere.
// - Only the last twelve bits shifted count; earlier bits drop out.
`timescale 1ns/100ps
`include "tcdl_cfg.svh"

module tcdl_loader
   import tcdl_pkg::*;
   #(parameter int N_CH = `TCDL_CHANNELS) (
   // System
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   // Serial port pins
   input wire logic serial_clk,
   input wire logic serial_sel_n,
   input wire logic serial_in,
   // Control pins
   input wire logic midscale_preset_n,
   input wire logic power_down_n,
   // Converter side
   output logic [N_CH*`TCDL_CODE_W-1:0] channel_output_code,
   output logic conv_power_on,
   // Status
   output logic word_loaded,
   output logic word_rejected,
   output logic [`TCDL_ADDR_W-1:0] last_addr
);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   logic [`TCDL_PIN_COUNT-1:0] pin_meta_r;
   logic [`TCDL_PIN_COUNT-1:0] pin_sync_r;
   logic [`TCDL_PIN_COUNT-1:0] pin_prev_r;
   logic sck_rise;
   logic sel_rise;
   logic sel_low;
   tcdl_state_t state_r;
   tcdl_state_t state_nxt;
   tcdl_word_t shift_r;
   tcdl_addr_t dec_addr;
   logic addr_ok;
   logic wr_en_r;
   tcdl_addr_t wr_addr_r;
   tcdl_code_t wr_code_r;
   logic conv_power_on_r;
   logic word_loaded_r;
   logic word_rejected_r;
   tcdl_addr_t last_addr_r;

   tcdl_chan_if #(.N_CH(N_CH)) chan_bus ();

   // ----------------------------------------------------------------------
   // Pin sampling
   // ----------------------------------------------------------------------
   // Three stages on every pin; the serial clock is only ever seen as a level
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_meta_r <= 4'hD; // Select and clock idle high, powered on
         pin_sync_r <= 4'hD;
         pin_prev_r <= 4'hD;
      end else if (ce) begin
         pin_meta_r <= {serial_clk, serial_sel_n, serial_in, power_down_n};
         pin_sync_r <= pin_meta_r;
         pin_prev_r <= pin_sync_r;
      end
   end

   // Edges are found from the second and third stages only
   assign sck_rise = pin_sync_r[`TCDL_PIN_SCK] & ~pin_prev_r[`TCDL_PIN_SCK];
   assign sel_rise = pin_sync_r[`TCDL_PIN_SEL] & ~pin_prev_r[`TCDL_PIN_SEL];
   assign sel_low = ~pin_sync_r[`TCDL_PIN_SEL];

   // ----------------------------------------------------------------------
   // Frame state
   // ----------------------------------------------------------------------
   // A frame is open while the sampled select reads low
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         TCDL_ST_IDLE: begin
            if (sel_low) begin
               state_nxt = TCDL_ST_SHIFT;
            end
         end
         TCDL_ST_SHIFT: begin
            if (!sel_low) begin
               state_nxt = TCDL_ST_IDLE;
            end
         end
         default: begin
            state_nxt = TCDL_ST_IDLE;
         end
      endcase
   end

   // State only moves on enabled cycles, so a frozen frame resumes intact
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= TCDL_ST_IDLE;
      end else if (ce) begin
         state_r <= state_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Input shift register
   // ----------------------------------------------------------------------
   // Twelve bits wide, so longer bursts push their oldest bits out the top
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         shift_r <= 12'h000;
      end else if (ce && sel_low && sck_rise) begin
         shift_r <= {shift_r[`TCDL_WORD_BITS-2:0], pin_sync_r[`TCDL_PIN_SDI]};
      end
   end

   // ----------------------------------------------------------------------
   // Word decode
   // ----------------------------------------------------------------------
   // Upper nibble is address only, lower byte is the code
   assign dec_addr = shift_r[`TCDL_ADDR_MSB:`TCDL_ADDR_LSB];
   assign addr_ok = (dec_addr < `TCDL_ADDR_W'(N_CH));

   // Load only on select rising out of a frame; a stray rise is ignored
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_en_r <= 1'b0;
         wr_addr_r <= 4'h0;
         wr_code_r <= 8'h00;
      end else if (ce) begin
         wr_en_r <= sel_rise && state_r == TCDL_ST_SHIFT
                    && addr_ok;
         wr_addr_r <= dec_addr;
         wr_code_r <= shift_r[`TCDL_CODE_MSB:`TCDL_CODE_LSB];
      end
   end

   // ----------------------------------------------------------------------
   // Status
   // ----------------------------------------------------------------------
   // Pulses line up with the write strobe, one cycle ahead of the new code
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         word_loaded_r <= 1'b0;
         word_rejected_r <= 1'b0;
         last_addr_r <= 4'h0;
      end else if (ce) begin
         word_loaded_r <= sel_rise && state_r == TCDL_ST_SHIFT && addr_ok;
         word_rejected_r <= sel_rise && state_r == TCDL_ST_SHIFT && !addr_ok;
         if (sel_rise && state_r == TCDL_ST_SHIFT) begin
            last_addr_r <= dec_addr;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Power control
   // ----------------------------------------------------------------------
   // Codes are untouched here, so waking up shows the old values at once
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         conv_power_on_r <= 1'b1;
      end else if (ce) begin
         conv_power_on_r <= pin_sync_r[`TCDL_PIN_PWR];
      end
   end

   // ----------------------------------------------------------------------
   // Channel register bank
   // ----------------------------------------------------------------------
   // Preset goes straight to the bank's async input, no sampling delay
   assign chan_bus.preset_n = midscale_preset_n;
   assign chan_bus.wr_en = wr_en_r;
   assign chan_bus.wr_addr = wr_addr_r;
   assign chan_bus.wr_code = wr_code_r;

   tcdl_chan_bank #(.N_CH(N_CH)) u_bank (
      .clk(clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .bus(chan_bus)
   );

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   genvar k;
   generate
      for (k = 0; k < N_CH; k++) begin : g_out
         // Channel 1 sits in the lowest byte
         assign channel_output_code[k*`TCDL_CODE_W +: `TCDL_CODE_W] =
            chan_bus.codes[k];
      end
   endgenerate

   // Status registers leave the block with no logic after them
   assign conv_power_on = conv_power_on_r;
   assign word_loaded = word_loaded_r;
   assign word_rejected = word_rejected_r;
   assign last_addr = last_addr_r;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // Newest sampled data bit enters at the bottom
   a_shift_edge: assert property (
      ce && sel_low && sck_rise
      |=> shift_r == {$past(shift_r[10:0]), $past(pin_sync_r[1])})
      else $error("bit not shifted on clock edge");

   // Serial clock is ignored outside a frame
   a_idle_hold: assert property (
      ce && !sel_low |=> $stable(shift_r))
      else $error("shift register moved with select high");

   // Select rise hands the whole word to the bank
   a_load_word: assert property (
      ce && sel_rise && state_r == TCDL_ST_SHIFT && addr_ok
      |=> wr_en_r && wr_code_r == $past(shift_r[7:0])
          && wr_addr_r == $past(shift_r[11:8]))
      else $error("select rise did not load the word");

   // Addresses past the last channel end in a reject, not a write
   a_bad_addr: assert property (
      ce && sel_rise && state_r == TCDL_ST_SHIFT && dec_addr >= 4'hC
      |=> !wr_en_r && word_rejected_r)
      else $error("out of range address wrote a channel");

   // A write strobe never lasts more than one cycle
   a_one_strobe: assert property (
      ce && wr_en_r |=> !wr_en_r)
      else $error("write strobe longer than one cycle");

   // Sampled power-down takes the converters down
   a_power_follow: assert property (
      ce && !pin_sync_r[0] |=> !conv_power_on_r)
      else $error("converters not powered down");

   // Oldest bit falls off the top, so only the last twelve remain
   a_last_twelve: assert property (
      ce && sel_low && sck_rise
      |=> shift_r[11:1] == $past(shift_r[10:0]))
      else $error("shift register did not drop its oldest bit");

   // Out of range status always names the address it threw away
   a_reject_addr: assert property (
      word_rejected_r |-> last_addr_r >= 4'hC)
      else $error("rejected word with a valid address");

   // A strobe can only carry a channel that exists
   a_strobe_range: assert property (
      wr_en_r |-> wr_addr_r < 4'hC)
      else $error("write strobe with address beyond last channel");

   // Low select always opens a frame on the next edge
   a_frame_open: assert property (
      ce && sel_low |=> state_r == TCDL_ST_SHIFT)
      else $error("frame not opened by low select");

   // Release of power-down brings the converters back at once
   a_power_wake: assert property (
      ce && pin_sync_r[0] |=> conv_power_on_r)
      else $error("converters stayed down after wake");

   // A word ends either loaded or rejected, never both
   a_one_verdict: assert property (
      !(word_loaded_r && word_rejected_r))
      else $error("word both loaded and rejected");

   // Completion pulse lasts a single cycle
   a_pulse_once: assert property (
      ce && word_loaded_r |=> !word_loaded_r)
      else $error("load pulse longer than one cycle");

   // Main scenarios: top channel, reject, wake, preset, stray clocks
   c_load: cover property (wr_en_r && wr_addr_r == 4'hB);
   c_reject: cover property (word_rejected_r);
   c_power: cover property (!conv_power_on_r ##1 conv_power_on_r);
   c_preset: cover property (!midscale_preset_n);
   c_stray: cover property (ce && !sel_low && sck_rise);

endmodule

// ===== tb/tcdl_host_model.sv
// Host side model driving the three-wire serial port of the loader
`timescale 1ns/100ps

module tcdl_host_model (
   // System
   input wire logic clk,
   // Serial port
   output logic serial_clk,
   output logic serial_sel_n,
   output logic serial_in
);
   // ------------------------------------------------------------
   // Serial timing
   // ------------------------------------------------------------
   // Four system cycles a phase gives an 800 ns serial period; a real
   // host may go to 33 MHz, which this sampled loader cannot follow
   localparam int HALF = 4;

   // Idle: clock parked high, select inactive
   initial begin
      serial_clk = 1'b1;
      serial_sel_n = 1'b1;
      serial_in = 1'b0;
   end

   task automatic half_wait();
      repeat (HALF) @(negedge clk);
   endtask

   // One frame of the low n bits of w, most significant bit first
   task automatic frame(input logic [15:0] w, input int n);
      serial_sel_n = 1'b0;
      half_wait();
      for (int i = n - 1; i >= 0; i--) begin
         serial_clk = 1'b0;
         serial_in = w[i];
         half_wait();
         serial_clk = 1'b1;
         half_wait();
      end
      // Clock is already high here when select rises
      serial_sel_n = 1'b1;
      // Released data line must not keep showing the last bit
      serial_in = ~serial_in;
   endtask

   // Clock pulses with select left high and a data pattern moving
   task automatic stray_clocks(input logic [11:0] w);
      for (int i = 11; i >= 0; i--) begin
         serial_clk = 1'b0;
         serial_in = w[i];
         half_wait();
         serial_clk = 1'b1;
         half_wait();
      end
   endtask
endmodule

// ===== tb/tcdl_loader_tb_top.sv
// Self-checking bench for the twelve-channel serial code loader
`timescale 1ns/100ps
`include "tcdl_cfg.svh"

module tcdl_loader_tb_top
   import tcdl_pkg::*;
   ;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic preset_n = 1'b1;
   logic pwr_n = 1'b1;
   logic ce = 1'b1;
   logic serial_clk;
   logic serial_sel_n;
   logic serial_in;
   logic [12*`TCDL_CODE_W-1:0] codes;
   logic conv_power_on;
   logic word_loaded;
   logic word_rejected;
   logic [`TCDL_ADDR_W-1:0] last_addr;
   tcdl_code_t exp_code [12];
   int bad_count = 0;
   int tests_run = 0;

   // 10 MHz system clock
   always #50 clk = ~clk;

   tcdl_host_model host_u (
      .clk(clk),
      .serial_clk(serial_clk),
      .serial_sel_n(serial_sel_n),
      .serial_in(serial_in)
   );

   // Clock enable is dropped only by the freeze scenario
   tcdl_loader dut_u (
      .clk(clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .serial_clk(serial_clk),
      .serial_sel_n(serial_sel_n),
      .serial_in(serial_in),
      .midscale_preset_n(preset_n),
      .power_down_n(pwr_n),
      .channel_output_code(codes),
      .conv_power_on(conv_power_on),
      .word_loaded(word_loaded),
      .word_rejected(word_rejected),
      .last_addr(last_addr)
   );

   // ------------------------------------------------------------
   // Shared helpers
   // ------------------------------------------------------------
   task automatic wrap_up();
      if (bad_count == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic fail(input string msg);
      bad_count++;
      $display("unexpected at %0t: %s", $time, msg);
   endtask

   task automatic check_codes();
      for (int k = 0; k < 12; k++) begin
         tests_run++;
         if (codes[k*8 +: 8] !== exp_code[k]) begin
            fail($sformatf("channel %0d holds %h", k + 1, codes[k*8 +: 8]));
         end
      end
   endtask

   // Bounded wait for the completion pulse, then idle spacing
   task automatic wait_pulse(input logic rej, input tcdl_addr_t a);
      int n;
      n = 0;
      while (word_loaded !== 1'b1 && word_rejected !== 1'b1) begin
         @(negedge clk);
         n++;
         if (n > 12) begin
            fail("no completion pulse");
            wrap_up();
         end
      end
      tests_run++;
      if (word_rejected !== rej || word_loaded !== ~rej
          || last_addr !== a) begin
         fail("wrong completion status");
      end
      repeat (3) @(negedge clk);
   endtask

   task automatic wait_power(input logic v);
      int n;
      n = 0;
      while (conv_power_on !== v) begin
         @(negedge clk);
         n++;
         if (n > 8) begin
            fail("power level not reached");
            wrap_up();
         end
      end
   endtask

   task automatic write_chan(input tcdl_addr_t a, input tcdl_code_t c);
      host_u.frame({4'h0, a, c}, 12);
      exp_code[a] = c;
      wait_pulse(1'b0, a);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      foreach (exp_code[k]) exp_code[k] = `TCDL_MIDSCALE;
      check_codes();
      tests_run++;
      if (conv_power_on !== 1'b1) begin
         fail("powered down after reset");
      end
   endtask

   // Descending order shows any order works; others stay put
   task automatic t_each_channel();
      for (int a = 11; a >= 0; a--) begin
         write_chan(4'(a), 8'(a * 23));
         check_codes();
      end
   endtask

   // Sixteen bits: the leading four must drop out
   task automatic t_long_word();
      host_u.frame(16'hF0FF, 16);
      exp_code[0] = 8'hFF;
      wait_pulse(1'b0, 4'h0);
      host_u.frame(16'h5B00, 16);
      exp_code[11] = 8'h00;
      wait_pulse(1'b0, 4'hB);
      check_codes();
   endtask

   task automatic t_bad_addr();
      for (int a = 12; a < 16; a++) begin
         host_u.frame({4'h0, 4'(a), 8'h5A}, 12);
         wait_pulse(1'b1, 4'(a));
         check_codes();
      end
   endtask

   // Stray clocks must not shift, so an empty frame reloads the old word
   task automatic t_stray_clocks();
      write_chan(4'h2, 8'hC3);
      host_u.stray_clocks(12'h4A5);
      host_u.frame(16'h0000, 0);
      wait_pulse(1'b0, 4'h2);
      check_codes();
   endtask

   task automatic t_power();
      pwr_n = 1'b0;
      wait_power(1'b0);
      check_codes();
      pwr_n = 1'b1;
      wait_power(1'b1);
      check_codes();
   endtask

   // Checked before any clock edge passes
   task automatic t_preset();
      preset_n = 1'b0;
      #10;
      foreach (exp_code[k]) exp_code[k] = `TCDL_MIDSCALE;
      check_codes();
      @(negedge clk);
      preset_n = 1'b1;
      repeat (2) @(negedge clk);
      write_chan(4'h4, 8'h01);
      check_codes();
   endtask

   // A frozen block ignores a whole frame and wakes with nothing pending
   task automatic t_freeze();
      ce = 1'b0;
      host_u.frame({4'h0, 4'h5, 8'h77}, 12);
      repeat (6) begin
         @(negedge clk);
         tests_run++;
         if (word_loaded !== 1'b0) begin
            fail("frozen block loaded a word");
         end
      end
      check_codes();
      ce = 1'b1;
      repeat (6) @(negedge clk);
      check_codes();
   endtask

   // Reset in mid-run must bring every channel back to midscale
   task automatic t_mid_reset();
      write_chan(4'h7, 8'h3C);
      check_codes();
      sys_rst = 1'b1;
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge clk);
      t_reset();
   endtask

   initial begin
      repeat (8) @(negedge clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge clk);
      t_reset();
      t_each_channel();
      t_long_word();
      t_bad_addr();
      t_stray_clocks();
      t_power();
      t_preset();
      t_freeze();
      t_mid_reset();
      wrap_up();
   end
endmodule
